// [src/rdt_pkg.sv]
// Purpose: Shared constants and types of the relay driver command block.
// Assumes: APB register access, 40 MHz clock, ASCII command characters.
// Notes:   Trigger lines are open drain and asserted low on the backplane.
package rdt_pkg;

    // Drivers and trigger lines.
    localparam int NUM_DRV   = 73;
    localparam int DRV_MAX   = 72;
    localparam int TRG_LINES = 8;
    localparam int LINE_MAX  = 7;

    // Register byte addresses.
    localparam logic [7:0] ADR_CHAR    = 8'h00;
    localparam logic [7:0] ADR_STB     = 8'h04;
    localparam logic [7:0] ADR_ISTAT   = 8'h08;
    localparam logic [7:0] ADR_IMASK   = 8'h0C;
    localparam logic [7:0] ADR_STATE   = 8'h10;
    localparam logic [7:0] ADR_CLOSED0 = 8'h20;
    localparam logic [7:0] ADR_CLOSED1 = 8'h24;
    localparam logic [7:0] ADR_CLOSED2 = 8'h28;

    // Interrupt status and mask layout.
    localparam int         IRQ_SYN_BIT = 0;
    localparam int         IRQ_TRG_BIT = 1;
    localparam logic [1:0] IMASK_RST   = 2'h3;
    localparam int         STB_RQS_BIT = 6;

    // State register fields.
    localparam int ST_EN_BIT    = 0;
    localparam int ST_VALID_BIT = 1;
    localparam int ST_FIRED_BIT = 2;
    localparam int ST_SYN_BIT   = 3;
    localparam int ST_TRG_BIT   = 4;
    localparam int ST_IN_LSB    = 8;
    localparam int ST_OUT_LSB   = 12;

    // Command characters.
    localparam logic [7:0] CH_SEMI  = 8'h3B;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_0     = 8'h30;
    localparam logic [7:0] CH_9     = 8'h39;
    localparam logic [7:0] CH_R     = 8'h52;
    localparam logic [7:0] CH_E     = 8'h45;
    localparam logic [7:0] CH_D     = 8'h44;
    localparam logic [7:0] CH_C     = 8'h43;
    localparam logic [7:0] CH_O     = 8'h4F;
    localparam logic [7:0] CH_T     = 8'h54;
    localparam logic [7:0] CH_S     = 8'h53;
    localparam logic [7:0] CH_I     = 8'h49;

    // Trigger output pulse width.
    localparam int         CLK_PERIOD_NS   = 25;
    localparam int         TRG_PULSE_NS    = 1000;
    localparam int         TRG_PULSE_CYC_I =
        (TRG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] TRG_PULSE_CYC   = 6'(TRG_PULSE_CYC_I);

    typedef logic [2:0] rdt_line_t;

    typedef enum logic [3:0] {
        PS_IDLE      = 4'h0,
        PS_RESET     = 4'h1,
        PS_ENABLE    = 4'h2,
        PS_DISABLE   = 4'h3,
        PS_CLOSE     = 4'h4,
        PS_OPEN      = 4'h5,
        PS_TRIG      = 4'h6,
        PS_SETUP_IN  = 4'h7,
        PS_SETUP_OUT = 4'h8,
        PS_IRQ_SEL   = 4'h9,
        PS_IRQ_SYN   = 4'hA,
        PS_IRQ_TRG   = 4'hB,
        PS_ERROR     = 4'hC
    } rdt_pst_e;

    typedef struct packed {
        logic      valid;
        rdt_line_t in_line;
        rdt_line_t out_line;
    } rdt_trg_cfg_s;

endpackage

// [src/rdt_trig_port.sv]
// Purpose: Trigger line input edge detection and output pulse generation.
// Assumes: Lines are asserted low and synchronous to clk.
// Notes:   A new fire during a pulse restarts the pulse on the new line.
`timescale 1ns/1ps
module rdt_trig_port (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Line selection and firing
    input  rdt_pkg::rdt_line_t     in_sel,
    input  rdt_pkg::rdt_line_t     out_sel,
    input  wire logic              fire,
    // Backplane lines
    input  wire logic [7:0]        trg_in,
    output logic      [7:0]        trg_oe_n,
    // Event on the selected input
    output logic                   seen
);
    import rdt_pkg::*;

    logic [TRG_LINES-1:0] prev_in;
    logic [TRG_LINES-1:0] next_prev_in;
    logic [TRG_LINES-1:0] next_oe_n;
    logic [5:0]           cnt;
    logic [5:0]           next_cnt;
    logic                 next_seen;

    always_comb begin
        next_prev_in = trg_in;
        // Only the selected line is looked at, so others never trigger.
        next_seen    = prev_in[in_sel] & ~trg_in[in_sel];
        next_cnt     = cnt;
        next_oe_n    = trg_oe_n;
        if (fire) begin
            next_cnt  = TRG_PULSE_CYC - 6'h01;
            next_oe_n = ~(8'h01 << out_sel);
        end else if (cnt != 6'h00) begin
            next_cnt = cnt - 6'h01;
        end else begin
            next_oe_n = 8'hFF;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_in  <= 8'hFF;
            trg_oe_n <= 8'hFF;
            cnt      <= 6'h00;
            seen     <= 1'b0;
        end else begin
            prev_in  <= next_prev_in;
            trg_oe_n <= next_oe_n;
            cnt      <= next_cnt;
            seen     <= next_seen;
        end
    end

endmodule

// [src/rdt_top.sv]
// Purpose: Command interpreter for a relay and logic driver module.
// Assumes: One ASCII character per APB write; uppercase commands only.
// Notes:   Characters are parsed at one per write with no stall.
//
// Summary of operation
// - Semicolon separated commands execute in order.
// - Close marks driver; output needs global enable.
// - Enable activates all closed drivers, 0 to 72.
// - With trigger setup, drivers wait for trigger.
// - Setup takes input line, then output line.
// - Trigger command pulses the selected output line.
// - Only the selected input line fires drivers.
// - Any of eight lines selectable each way.
// - Enabled syntax errors raise an interrupt.
// - Enabled external triggers raise an interrupt.
// - Status byte bit 6 shows raised interrupt.
// - Bit 6 clear after reset or no cause.
`timescale 1ns/1ps
module rdt_top (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Driver outputs
    output logic [rdt_pkg::NUM_DRV-1:0] drv_out,
    // Trigger lines
    input  wire logic [7:0]        ttl_trg_in,
    output logic      [7:0]        ttl_trg_out,
    output logic      [7:0]        ttl_trg_oe_n,
    // Interrupt
    output logic                   irq
);
    import rdt_pkg::*;

    logic              access;
    logic              done;
    logic              ch_valid;
    logic [7:0]        ch;
    logic              next_pready;
    logic [31:0]       next_prdata;
    logic              next_pslverr;
    rdt_pst_e          pst;
    rdt_pst_e          next_pst;
    logic [6:0]        num;
    logic [6:0]        next_num;
    rdt_line_t         num_in;
    rdt_line_t         next_num_in;
    logic              have;
    logic              next_have;
    logic              is_term;
    logic              is_digit;
    logic              bad;
    logic [10:0]       acc;
    logic [10:0]       lim;
    logic              do_reset;
    logic              do_en;
    logic              do_dis;
    logic              do_close;
    logic              do_open;
    logic              do_trig;
    logic              do_setup;
    logic              do_syn;
    logic              do_trg;
    logic              syn_err;
    logic [NUM_DRV-1:0] closed;
    logic [NUM_DRV-1:0] next_closed;
    logic              out_en;
    logic              next_out_en;
    rdt_trg_cfg_s      trigger_line_setup;
    rdt_trg_cfg_s      next_setup;
    logic              fired;
    logic              next_fired;
    logic              irq_on_syntax_error;
    logic              next_irq_syn;
    logic              irq_on_trigger_event;
    logic              next_irq_trg;
    logic              trig_seen;
    logic              trig_fire;
    logic [1:0]        istat;
    logic [1:0]        next_istat;
    logic [1:0]        imask;
    logic [1:0]        next_imask;
    logic [NUM_DRV-1:0] next_drv;

    assign access    = psel & penable;
    assign done      = access & pready;
    assign ch_valid  = done & pwrite & (paddr == ADR_CHAR);
    assign ch        = pwdata[7:0];
    assign trig_fire = do_trig & trigger_line_setup.valid;

    // APB answer: one wait state, read data captured before completion.
    always_comb begin
        next_pready  = access & ~pready;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (access & ~pready) begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                ADR_CHAR:    next_prdata = 32'h0000_0000;
                ADR_STB:     next_prdata[STB_RQS_BIT] = |istat;
                ADR_ISTAT:   next_prdata[1:0] = istat;
                ADR_IMASK:   next_prdata[1:0] = imask;
                ADR_STATE: begin
                    next_prdata[ST_EN_BIT]    = out_en;
                    next_prdata[ST_VALID_BIT] = trigger_line_setup.valid;
                    next_prdata[ST_FIRED_BIT] = fired;
                    next_prdata[ST_SYN_BIT]   = irq_on_syntax_error;
                    next_prdata[ST_TRG_BIT]   = irq_on_trigger_event;
                    next_prdata[ST_IN_LSB +: 3]  = trigger_line_setup.in_line;
                    next_prdata[ST_OUT_LSB +: 3] = trigger_line_setup.out_line;
                end
                ADR_CLOSED0: next_prdata = closed[31:0];
                ADR_CLOSED1: next_prdata = closed[63:32];
                ADR_CLOSED2: next_prdata[8:0] = closed[72:64];
                default:     next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Character parser; each command runs when its terminator arrives.
    always_comb begin
        is_term  = (ch == CH_SEMI) | (ch == CH_CR) | (ch == CH_LF);
        is_digit = (ch >= CH_0) & (ch <= CH_9);
        acc      = 11'(num) * 11'h00A + 11'(ch[3:0]);
        lim      = ((pst == PS_SETUP_IN) | (pst == PS_SETUP_OUT)) ?
                   11'(LINE_MAX) : 11'(DRV_MAX);
        next_pst    = pst;
        next_num    = num;
        next_num_in = num_in;
        next_have   = have;
        bad      = 1'b0;
        do_reset = 1'b0;
        do_en    = 1'b0;
        do_dis   = 1'b0;
        do_close = 1'b0;
        do_open  = 1'b0;
        do_trig  = 1'b0;
        do_setup = 1'b0;
        do_syn   = 1'b0;
        do_trg   = 1'b0;
        syn_err  = 1'b0;
        if (ch_valid && ch != CH_SPACE) begin
            next_num  = (pst == PS_IDLE) ? 7'h00 : num;
            next_have = (pst == PS_IDLE) ? 1'b0 : have;
            unique case (pst)
                PS_IDLE: begin
                    if (!is_term) begin
                        unique case (ch)
                            CH_R:    next_pst = PS_RESET;
                            CH_E:    next_pst = PS_ENABLE;
                            CH_D:    next_pst = PS_DISABLE;
                            CH_C:    next_pst = PS_CLOSE;
                            CH_O:    next_pst = PS_OPEN;
                            CH_T:    next_pst = PS_TRIG;
                            CH_I:    next_pst = PS_IRQ_SEL;
                            default: bad = 1'b1;
                        endcase
                    end
                end
                PS_RESET, PS_ENABLE, PS_DISABLE, PS_IRQ_SYN, PS_IRQ_TRG: begin
                    if (is_term) begin
                        next_pst = PS_IDLE;
                        do_reset = (pst == PS_RESET);
                        do_en    = (pst == PS_ENABLE);
                        do_dis   = (pst == PS_DISABLE);
                        do_syn   = (pst == PS_IRQ_SYN);
                        do_trg   = (pst == PS_IRQ_TRG);
                    end else begin
                        bad = 1'b1;
                    end
                end
                PS_CLOSE, PS_OPEN, PS_SETUP_IN, PS_SETUP_OUT: begin
                    if (is_digit) begin
                        if (acc > lim) begin
                            bad = 1'b1;
                        end else begin
                            next_num  = acc[6:0];
                            next_have = 1'b1;
                        end
                    end else if (pst == PS_SETUP_IN && ch == CH_COMMA &&
                                 have) begin
                        next_num_in = num[2:0];
                        next_num    = 7'h00;
                        next_have   = 1'b0;
                        next_pst    = PS_SETUP_OUT;
                    end else if (is_term && have && pst != PS_SETUP_IN) begin
                        next_pst = PS_IDLE;
                        do_close = (pst == PS_CLOSE);
                        do_open  = (pst == PS_OPEN);
                        do_setup = (pst == PS_SETUP_OUT);
                    end else begin
                        bad = 1'b1;
                    end
                end
                PS_TRIG: begin
                    if (is_term) begin
                        next_pst = PS_IDLE;
                        do_trig  = 1'b1;
                    end else if (ch == CH_S) begin
                        next_pst = PS_SETUP_IN;
                    end else begin
                        bad = 1'b1;
                    end
                end
                PS_IRQ_SEL: begin
                    if (ch == CH_E) begin
                        next_pst = PS_IRQ_SYN;
                    end else if (ch == CH_T) begin
                        next_pst = PS_IRQ_TRG;
                    end else begin
                        bad = 1'b1;
                    end
                end
                PS_ERROR: bad = 1'b1;
                default:  next_pst = PS_IDLE;
            endcase
            if (bad) begin
                syn_err  = is_term;
                next_pst = is_term ? PS_IDLE : PS_ERROR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pst    <= PS_IDLE;
            num    <= 7'h00;
            num_in <= 3'h0;
            have   <= 1'b0;
        end else begin
            pst    <= next_pst;
            num    <= next_num;
            num_in <= next_num_in;
            have   <= next_have;
        end
    end

    rdt_trig_port u_trig (
        .clk      (clk),
        .rstn     (rstn),
        .in_sel   (trigger_line_setup.in_line),
        .out_sel  (trigger_line_setup.out_line),
        .fire     (trig_fire),
        .trg_in   (ttl_trg_in),
        .trg_oe_n (ttl_trg_oe_n),
        .seen     (trig_seen)
    );

    // Command effects and trigger arming; hardware sets win over clears.
    always_comb begin
        next_closed  = closed;
        next_out_en  = out_en;
        next_setup   = trigger_line_setup;
        next_fired   = fired;
        next_irq_syn = irq_on_syntax_error;
        next_irq_trg = irq_on_trigger_event;
        next_istat   = istat;
        next_imask   = imask;
        if (done && !pwrite && paddr == ADR_ISTAT) begin
            // Only bits that were returned are cleared.
            next_istat = istat & ~prdata[1:0];
        end
        if (done && pwrite && paddr == ADR_IMASK) begin
            next_imask = pwdata[1:0];
        end
        if (do_reset) begin
            next_closed  = '0;
            next_out_en  = 1'b0;
            next_setup   = '0;
            next_fired   = 1'b0;
            next_irq_syn = 1'b0;
            next_irq_trg = 1'b0;
            next_istat   = 2'h0;
        end
        if (do_en) begin
            next_out_en = 1'b1;
        end
        if (do_dis) begin
            next_out_en = 1'b0;
        end
        if (do_close) begin
            next_closed[num] = 1'b1;
        end
        if (do_open) begin
            next_closed[num] = 1'b0;
        end
        if (do_setup) begin
            next_setup.valid    = 1'b1;
            next_setup.in_line  = num_in;
            next_setup.out_line = num[2:0];
            next_fired          = 1'b0;
        end
        if (do_syn) begin
            next_irq_syn = 1'b1;
        end
        if (do_trg) begin
            next_irq_trg = 1'b1;
        end
        if (trig_seen && trigger_line_setup.valid) begin
            next_fired = 1'b1;
            if (irq_on_trigger_event) begin
                next_istat[IRQ_TRG_BIT] = 1'b1;
            end
        end
        if (syn_err && irq_on_syntax_error) begin
            next_istat[IRQ_SYN_BIT] = 1'b1;
        end
        // Armed drivers stay off until the selected line has fired.
        if (out_en && (!trigger_line_setup.valid || fired)) begin
            next_drv = closed;
        end else begin
            next_drv = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            closed               <= '0;
            out_en               <= 1'b0;
            trigger_line_setup   <= '0;
            fired                <= 1'b0;
            irq_on_syntax_error  <= 1'b0;
            irq_on_trigger_event <= 1'b0;
            istat                <= 2'h0;
            imask                <= IMASK_RST;
            drv_out              <= '0;
            irq                  <= 1'b0;
            ttl_trg_out          <= 8'h00;
        end else begin
            closed               <= next_closed;
            out_en               <= next_out_en;
            trigger_line_setup   <= next_setup;
            fired                <= next_fired;
            irq_on_syntax_error  <= next_irq_syn;
            irq_on_trigger_event <= next_irq_trg;
            istat                <= next_istat;
            imask                <= next_imask;
            drv_out              <= next_drv;
            irq                  <= |(istat & imask);
            ttl_trg_out          <= 8'h00;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    drv_gate_a: assert property (|drv_out |-> $past(out_en))
        else $error("driver active while outputs disabled");
    close_mark_a: assert property (do_close |=> closed[$past(num)])
        else $error("close did not mark driver");
    enable_all_a: assert property (
        out_en && !trigger_line_setup.valid |=> drv_out == $past(closed))
        else $error("enabled closed drivers not active");
    hold_armed_a: assert property (
        trigger_line_setup.valid && !fired |=> drv_out == '0)
        else $error("armed driver active before trigger");
    setup_load_a: assert property (
        do_setup |=> trigger_line_setup.in_line == $past(num_in) &&
                     trigger_line_setup.out_line == $past(num[2:0]))
        else $error("trigger setup lines wrong");
    trig_pulse_a: assert property (
        trig_fire |=> !ttl_trg_oe_n[$past(trigger_line_setup.out_line)] [*8])
        else $error("trigger pulse missing on output line");
    fire_cause_a: assert property ($rose(fired) |-> $past(trig_seen))
        else $error("driver armed without selected line pulse");
    syn_irq_a: assert property (
        syn_err && irq_on_syntax_error |=> istat[IRQ_SYN_BIT] ##1
        (irq || !imask[IRQ_SYN_BIT]))
        else $error("syntax error interrupt not raised");
    trg_irq_a: assert property (
        trig_seen && trigger_line_setup.valid && irq_on_trigger_event
        |=> istat[IRQ_TRG_BIT])
        else $error("trigger interrupt not raised");
    stb_bit_a: assert property (
        $rose(pready) && !pwrite && paddr == ADR_STB
        |-> prdata[STB_RQS_BIT] == $past(|istat))
        else $error("status byte bit 6 wrong");
    reset_cmd_a: assert property (
        do_reset |=> closed == '0 && !out_en && !trigger_line_setup.valid &&
                     !irq_on_syntax_error && !irq_on_trigger_event ##1
                     drv_out == '0)
        else $error("reset command left state behind");
    reset_stb_a: assert property (
        do_reset && !trig_seen |=> istat == 2'h0)
        else $error("reset command left interrupt cause");

    setup_seen_c: cover property (do_setup);
    trig_act_c: cover property ($rose(fired) && out_en && |closed);
    syn_err_c: cover property (syn_err && irq_on_syntax_error);
    irq_rise_c: cover property ($rose(irq));

endmodule

// [verif/rdt_bp_model.sv]
// Purpose: Backplane trigger lines with pull-ups and other modules' pulls.
// Assumes: Lines are open drain and asserted low.
// Notes:   Any party pulling low wins; a released line rises to the pull-up.
`timescale 1ns/1ps
module rdt_bp_model (
    // Device side
    input  wire logic [7:0] dev_oe_n,
    // Other modules on the backplane
    input  wire logic [7:0] ext_pull_n,
    // Resolved lines
    output logic      [7:0] line_lvl
);
    import rdt_pkg::*;
    assign line_lvl = dev_oe_n & ext_pull_n;
endmodule

// [verif/tb_top.sv]
// Purpose: Self-checking bench of the relay driver command block.
// Assumes: APB master in the bench; commands sent one character a write.
// Notes:   Trigger lines loop back through the backplane model.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_top;
    import rdt_pkg::*;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, ttl_oe_n, ext_n, ttl_lvl, ttl_out;
    logic [31:0] pwdata, prdata, rd;
    logic [72:0] drv_out;
    logic        er;
    int          error_cnt, n_tests, cyc;

    rdt_top dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .drv_out(drv_out),
        .ttl_trg_in(ttl_lvl), .ttl_trg_out(ttl_out), .ttl_trg_oe_n(ttl_oe_n),
        .irq(irq));
    rdt_bp_model bp_u (.dev_oe_n(ttl_oe_n), .ext_pull_n(ext_n),
        .line_lvl(ttl_lvl));

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    // A hang must still reach the verdict, so the ceiling counts as a miss.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // Only the bench ceiling may end this wait.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic send(input string s);
        for (int i = 0; i < s.len(); i++) apb(1, ADR_CHAR, {24'h0, s[i]});
        tick(3);
    endtask

    task automatic t_close();
        send("R;E;D\n");
        `CHK(drv_out, 73'h0)
        apb(0, ADR_STATE, 32'h0);
        `CHK(rd[0], 1'b0)
        send("C0;C72\n");
        `CHK(drv_out, 73'h0)
        apb(0, ADR_CLOSED2, 32'h0);
        `CHK(rd[8:0], 9'h100)
        send("E\n");
        `CHK(drv_out, {1'b1, 71'h0, 1'b1})
        send("R\n");
        `CHK(drv_out, 73'h0)
        apb(0, ADR_STATE, 32'h0);
        `CHK(rd[4:0], 5'h0)
        $display("close and enable test done");
    endtask

    task automatic t_trig(input int in_l, input int out_l);
        int lo;
        lo = 0;
        send("R\n");
        send($sformatf("TS %0d,%0d;C72;E\n", in_l, out_l));
        `CHK(drv_out[72], 1'b0)
        apb(0, ADR_STATE, 32'h0);
        `CHK({rd[10:8], rd[14:12]}, {3'(in_l), 3'(out_l)})
        ext_n[(in_l + 2) % 8] <= 1'b0;
        tick(3);
        ext_n <= 8'hFF;
        tick(3);
        `CHK(drv_out[72], 1'b0)
        // Count from the terminator edge, so no pulse cycle is missed.
        apb(1, ADR_CHAR, {24'h0, CH_T});
        apb(1, ADR_CHAR, {24'h0, CH_LF});
        repeat (60) begin
            @(posedge clk);
            if (ttl_oe_n[out_l] === 1'b0) lo++;
        end
        `CHK(lo, TRG_PULSE_CYC_I)
        `CHK(ttl_out, 8'h00)
        `CHK(drv_out[72], 1'(in_l == out_l))
    endtask

    task automatic t_irq();
        send("R\n");
        apb(0, ADR_STB, 32'h0);
        `CHK(rd[7:0], 8'h00)
        send("IE\n");
        send("ASASAS\n");
        apb(0, ADR_STB, 32'h0);
        `CHK(rd[7:0], 8'h40)
        `CHK(irq, 1'b1)
        apb(1, ADR_IMASK, 32'h0);
        tick(3);
        `CHK(irq, 1'b0)
        apb(1, ADR_IMASK, 32'h3);
        apb(0, ADR_ISTAT, 32'h0);
        `CHK(rd[1:0], 2'h1)
        send("R\n");
        apb(0, ADR_STB, 32'h0);
        `CHK(rd[7:0], 8'h00)
        send("TS 0,0;IT;C72;E\n");
        send("T\n");
        tick(60);
        apb(0, ADR_STB, 32'h0);
        `CHK(rd[7:0], 8'h40)
        apb(0, ADR_ISTAT, 32'h0);
        `CHK(rd[1:0], 2'h2)
        apb(0, 8'h30, 32'h0);
        `CHK(er, 1'b1)
        send("R\n");
        $display("interrupt test done");
    endtask

    initial begin
        rstn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_n = 8'hFF;
        tick(6);
        rstn <= 1;
        t_close();
        for (int i = 0; i <= LINE_MAX; i++) begin
            t_trig(i, i);
            t_trig(i, (i + 1) % TRG_LINES);
        end
        $display("trigger line test done");
        t_irq();
        print_verdict();
    end
endmodule
